// *** rtl/mau_map.vh ***
`ifndef MAU_MAP_VH
`define MAU_MAP_VH

// Byte register indices on the unit's register port.
`define MAU_IDX_CMD        4'h4
`define MAU_IDX_STATUS     4'h5
`define MAU_IDX_MPL_LO     4'h6
`define MAU_IDX_MPL_HI     4'h7
`define MAU_IDX_MPC_LO     4'h8
`define MAU_IDX_MPC_HI     4'h9
`define MAU_IDX_RES_B0     4'hA
`define MAU_IDX_RES_B1     4'hB
`define MAU_IDX_RES_B2     4'hC
`define MAU_IDX_RES_B3     4'hD

// Command register fields.
`define MAU_CMD_ENABLE     7
`define MAU_CMD_CLEAR      3
`define MAU_CMD_MODE_HI    2
`define MAU_CMD_MODE_LO    0
`define MAU_CMD_ONES       8'h70
`define MAU_CMD_RESET      8'h70

// Mode field bits and codes.
`define MAU_MODE_ACC       0
`define MAU_MODE_SIGNED    1
`define MAU_MODE_UMUL      3'h0
`define MAU_MODE_UMAC      3'h1
`define MAU_MODE_SMUL      3'h2
`define MAU_MODE_SMAC      3'h3

// Status register fields.
`define MAU_ST_CARRY       4
`define MAU_ST_ZERO        3
`define MAU_ST_SIGN        2
`define MAU_ST_OVERFLOW    1
`define MAU_ST_BUSY        0
`define MAU_ST_ONES        8'hE0
`define MAU_ST_RESET       8'hE0

// Calculation time in machine cycles; one machine cycle is one clock.
`define MAU_BUSY_A_MCYC      3

`endif

// *** rtl/mau_engine.v ***
`timescale 1ns/1ps
`include "mau_map.vh"

module mau_engine #(
	parameter BUSY_A_CYCLES = `MAU_BUSY_A_MCYC
) (
	// Clock and reset
	input  wire        clk,
	input  wire        rst,
	// Operation request
	input  wire        start,
	input  wire [2:0]  mode,
	input  wire [15:0] op_a,
	input  wire [15:0] op_b,
	input  wire [31:0] addend,
	// Completion
	output reg         busy,
	output reg         done,
	output reg  [31:0] result,
	output reg         carry,
	output reg         overflow
);

	reg  [2:0]  cnt;
	reg  [2:0]  mode_l;
	reg  [15:0] a_l;
	reg  [15:0] b_l;
	reg  [31:0] add_l;
	wire        sgn = mode_l[`MAU_MODE_SIGNED];
	wire        acc = mode_l[`MAU_MODE_ACC];
	wire signed [16:0] sa = {sgn & a_l[15], a_l};
	wire signed [16:0] sb = {sgn & b_l[15], b_l};
	wire signed [33:0] prod_full = sa * sb;
	wire [31:0] prod = prod_full[31:0];
	wire [32:0] sum = {1'b0, prod} + {1'b0, add_l};
	wire [31:0] res = acc ? sum[31:0] : prod;

	always @(posedge clk) begin
		if (rst) begin
			busy <= 1'b0;
			done <= 1'b0;
			cnt <= 3'h0;
			mode_l <= 3'h0;
			a_l <= 16'h0000;
			b_l <= 16'h0000;
			add_l <= 32'h0000_0000;
			result <= 32'h0000_0000;
			carry <= 1'b0;
			overflow <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start && !busy) begin
				busy <= 1'b1;
				cnt <= BUSY_A_CYCLES[2:0] - 3'h1;
				mode_l <= mode;
				a_l <= op_a;
				b_l <= op_b;
				add_l <= addend;
			end else if (busy) begin
				if (cnt == 3'h0) begin
					busy <= 1'b0;
					done <= 1'b1;
					result <= res;
					carry <= acc & sum[32];
					// Same-sign operands giving a result of the other sign.
					overflow <= acc & sgn & (prod[31] == add_l[31])
						& (sum[31] != prod[31]);
				end else begin
					cnt <= cnt - 3'h1;
				end
			end
		end
	end

endmodule

// *** rtl/mau_top.v ***
`timescale 1ns/1ps
`include "mau_map.vh"

module mau_top #(
	parameter BUSY_A_CYCLES = `MAU_BUSY_A_MCYC
) (
	// Clock and reset
	input  wire       CLK_IN,
	input  wire       SYS_RST_IN,
	// Low-power operating mode entry
	input  wire       LOW_POWER_IN,
	// Byte register port
	input  wire [3:0] ADDR_IN,
	input  wire       WR_IN,
	input  wire [7:0] WDATA_IN,
	output reg  [7:0] RDATA_OUT,
	// Unit state
	output reg        BUSY_OUT,
	output reg        ENABLE_OUT
);

	reg  [7:0]  command_reg;
	reg  [4:0]  status_reg;
	reg  [15:0] multiplier;
	reg  [15:0] multiplicand;
	reg  [7:0]  mpc_low_stage;
	reg         mpc_low_armed;
	reg  [31:0] result_bytes;
	reg  [31:0] addend_bytes;
	reg         pending;
	reg         start;
	reg  [2:0]  run_mode;

	wire        eng_busy;
	wire        eng_done;
	wire [31:0] eng_result;
	wire        eng_carry;
	wire        eng_overflow;

	wire        unit_enable    = command_reg[`MAU_CMD_ENABLE];
	wire [2:0]  arith_mode_sel =
		command_reg[`MAU_CMD_MODE_HI:`MAU_CMD_MODE_LO];
	wire        busy_a = eng_busy | pending | start;
	wire        wr_cmd  = WR_IN && (ADDR_IN == `MAU_IDX_CMD);
	wire        wr_mpll = WR_IN && (ADDR_IN == `MAU_IDX_MPL_LO);
	wire        wr_mplh = WR_IN && (ADDR_IN == `MAU_IDX_MPL_HI);
	wire        wr_mpcl = WR_IN && (ADDR_IN == `MAU_IDX_MPC_LO);
	wire        wr_mpch = WR_IN && (ADDR_IN == `MAU_IDX_MPC_HI);
	wire        wr_add  = WR_IN && (ADDR_IN >= `MAU_IDX_RES_B0)
		&& (ADDR_IN <= `MAU_IDX_RES_B3);
	wire [3:0]  add_off = ADDR_IN - `MAU_IDX_RES_B0;
	wire [1:0]  add_sel = add_off[1:0];
	wire        disabling = wr_cmd && unit_enable
		&& !WDATA_IN[`MAU_CMD_ENABLE];
	wire        clear_req = wr_cmd && WDATA_IN[`MAU_CMD_CLEAR]
		&& !busy_a;
	wire [31:0] next_addend = put_byte(addend_bytes, add_sel, WDATA_IN);

	// Replaces one byte lane of a 32-bit word.
	function [31:0] put_byte;
		input [31:0] word;
		input [1:0]  lane;
		input [7:0]  data;
		begin
			put_byte = word;
			case (lane)
			2'd0: put_byte[7:0] = data;
			2'd1: put_byte[15:8] = data;
			2'd2: put_byte[23:16] = data;
			default: put_byte[31:24] = data;
			endcase
		end
	endfunction

	// Picks one byte lane of a 32-bit word.
	function [7:0] get_byte;
		input [31:0] word;
		input [1:0]  lane;
		begin
			case (lane)
			2'd0: get_byte = word[7:0];
			2'd1: get_byte = word[15:8];
			2'd2: get_byte = word[23:16];
			default: get_byte = word[31:24];
			endcase
		end
	endfunction

	mau_engine #(
		.BUSY_A_CYCLES(BUSY_A_CYCLES)
	) u_engine (
		.clk      (CLK_IN),
		// Disabling aborts a running calculation so no late result lands.
		.rst      (SYS_RST_IN | LOW_POWER_IN | disabling),
		.start    (start),
		.mode     (run_mode),
		.op_a     (multiplier),
		.op_b     (multiplicand),
		.addend   (addend_bytes),
		.busy     (eng_busy),
		.done     (eng_done),
		.result   (eng_result),
		.carry    (eng_carry),
		.overflow (eng_overflow)
	);

	// Command register.
	always @(posedge CLK_IN) begin
		if (SYS_RST_IN || LOW_POWER_IN) begin
			command_reg <= `MAU_CMD_RESET;
		end else if (wr_cmd) begin
			// Mode and enable take the written value; clear only if idle.
			command_reg <= (WDATA_IN & ~(8'h01 << `MAU_CMD_CLEAR))
				| `MAU_CMD_ONES;
			command_reg[`MAU_CMD_CLEAR] <= clear_req;
		end else begin
			command_reg[`MAU_CMD_CLEAR] <= 1'b0;
		end
	end

	// Multiplier: plain byte writes.
	always @(posedge CLK_IN) begin
		if (SYS_RST_IN || LOW_POWER_IN || disabling) begin
			multiplier <= 16'h0000;
		end else if (wr_mpll) begin
			multiplier[7:0] <= WDATA_IN;
		end else if (wr_mplh) begin
			multiplier[15:8] <= WDATA_IN;
		end
	end

	// Multiplicand: low byte lands at once unless the engine is busy, high byte only after a low one.
	always @(posedge CLK_IN) begin
		if (SYS_RST_IN || LOW_POWER_IN || disabling) begin
			multiplicand <= 16'h0000;
			mpc_low_stage <= 8'h00;
			mpc_low_armed <= 1'b0;
		end else if (unit_enable && wr_mpcl) begin
			mpc_low_stage <= WDATA_IN;
			mpc_low_armed <= 1'b1;
			if (!eng_busy) begin
				multiplicand[7:0] <= WDATA_IN;
			end
		end else if (unit_enable && wr_mpch && mpc_low_armed) begin
			multiplicand <= {WDATA_IN, mpc_low_stage};
			mpc_low_armed <= 1'b0;
		end
	end

	// Start sequencing; one further set may queue behind a running one.
	always @(posedge CLK_IN) begin
		if (SYS_RST_IN || LOW_POWER_IN || disabling) begin
			start <= 1'b0;
			pending <= 1'b0;
			run_mode <= `MAU_MODE_UMUL;
		end else begin
			start <= 1'b0;
			if (unit_enable && wr_mpch && mpc_low_armed) begin
				if (eng_busy || start) begin
					pending <= 1'b1;
				end else begin
					start <= 1'b1;
					run_mode <= arith_mode_sel;
				end
			end else if (pending && !eng_busy && !eng_done && !start) begin
				// Waits one cycle after done so the copied addend is used.
				pending <= 1'b0;
				start <= 1'b1;
				run_mode <= arith_mode_sel;
			end
		end
	end

	// Result, addend and status.
	always @(posedge CLK_IN) begin
		if (SYS_RST_IN || LOW_POWER_IN || disabling || clear_req) begin
			result_bytes <= 32'h0000_0000;
			addend_bytes <= 32'h0000_0000;
			status_reg <= 5'h00;
		end else if (eng_done) begin
			result_bytes <= eng_result;
			if (run_mode[`MAU_MODE_ACC]) begin
				addend_bytes <= eng_result;
			end
			status_reg[`MAU_ST_CARRY] <= eng_carry;
			status_reg[`MAU_ST_OVERFLOW] <= eng_overflow;
			status_reg[`MAU_ST_SIGN] <= eng_result[31];
			status_reg[`MAU_ST_ZERO] <=
				(eng_result == 32'h0000_0000);
		end else if (unit_enable && wr_add && !busy_a) begin
			addend_bytes <= next_addend;
			result_bytes <= next_addend;
		end
	end

	// Read data and state outputs; reads have no side effects.
	always @(posedge CLK_IN) begin
		if (SYS_RST_IN) begin
			RDATA_OUT <= 8'h00;
			BUSY_OUT <= 1'b0;
			ENABLE_OUT <= 1'b0;
		end else begin
			BUSY_OUT <= busy_a;
			ENABLE_OUT <= unit_enable;
			case (ADDR_IN)
			`MAU_IDX_CMD: RDATA_OUT <= command_reg;
			`MAU_IDX_STATUS: RDATA_OUT <= `MAU_ST_ONES
				| {3'b000, status_reg[4:1], busy_a};
			`MAU_IDX_MPL_LO: RDATA_OUT <= multiplier[7:0];
			`MAU_IDX_MPL_HI: RDATA_OUT <= multiplier[15:8];
			`MAU_IDX_MPC_LO: RDATA_OUT <= multiplicand[7:0];
			`MAU_IDX_MPC_HI: RDATA_OUT <= multiplicand[15:8];
			`MAU_IDX_RES_B0, `MAU_IDX_RES_B1,
			`MAU_IDX_RES_B2, `MAU_IDX_RES_B3: begin
				RDATA_OUT <= get_byte(result_bytes, add_sel);
			end
			default: RDATA_OUT <= 8'h00;
			endcase
		end
	end

endmodule

// *** sim/mau_checker.sv ***
`timescale 1ns/1ps
module mau_checker #(
	parameter BUSY_A_CYCLES = 3
) (
	// Clock and reset
	input wire       CLK_IN,
	input wire       SYS_RST_IN,
	// Unit inputs
	input wire       LOW_POWER_IN,
	input wire [3:0] ADDR_IN,
	input wire       WR_IN,
	input wire [7:0] WDATA_IN,
	// Unit outputs
	input wire [7:0] RDATA_OUT,
	input wire       BUSY_OUT,
	input wire       ENABLE_OUT
);
	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (SYS_RST_IN);
	wire       cmd_wr = WR_IN && ADDR_IN == 4'h4;
	wire       cmd_off = cmd_wr && !WDATA_IN[7];
	reg  [7:0] bcnt;
	// Length of the current run of busy cycles.
	always @(posedge CLK_IN)
		bcnt <= (SYS_RST_IN || !BUSY_OUT) ? 8'h00 : bcnt + 8'h01;
	sequence s_lo;
		WR_IN && ADDR_IN == 4'h8 && !LOW_POWER_IN;
	endsequence
	sequence s_hi;
		WR_IN && ADDR_IN == 4'h9 && !BUSY_OUT && ENABLE_OUT;
	endsequence
	sequence s_clr;
		cmd_wr && WDATA_IN[3] && !LOW_POWER_IN;
	endsequence
	a_busy_start: assert property (s_lo ##[1:4] s_hi |-> ##[1:4] BUSY_OUT)
		else $error("no busy after multiplicand write");
	a_busy_min: assert property ($fell(BUSY_OUT) && !$past(SYS_RST_IN)
		&& !$past(LOW_POWER_IN, 2) |-> bcnt >= BUSY_A_CYCLES)
		else $error("busy run too short");
	a_busy_bound: assert property (bcnt < 8'h20)
		else $error("busy stuck high");
	a_status_view: assert property (ADDR_IN == 4'h5 |=>
		RDATA_OUT[0] == BUSY_OUT && RDATA_OUT[7:5] == 3'b111)
		else $error("status byte wrong");
	a_unmapped_zero: assert property ((ADDR_IN < 4'h4 || ADDR_IN > 4'hD)
		|=> RDATA_OUT == 8'h00)
		else $error("unmapped byte not zero");
	a_clear_pulse: assert property (s_clr ##1 (!BUSY_OUT && ENABLE_OUT
		&& !WR_IN && ADDR_IN == 4'h4) ##1 ADDR_IN == 4'h4
		|-> RDATA_OUT[3] ##1 !RDATA_OUT[3])
		else $error("clear bit not a one cycle pulse");
	a_clear_busy: assert property (s_clr ##1 (BUSY_OUT && !WR_IN
		&& ADDR_IN == 4'h4) |=> !RDATA_OUT[3])
		else $error("clear bit set while busy");
	a_enable_on: assert property (cmd_wr && WDATA_IN[7] && !LOW_POWER_IN
		|-> ##2 ENABLE_OUT)
		else $error("enable did not take");
	a_enable_off: assert property ($fell(ENABLE_OUT) |-> $past(cmd_off, 2)
		|| $past(LOW_POWER_IN, 2) || $past(SYS_RST_IN))
		else $error("enable dropped by itself");
	a_low_power: assert property (LOW_POWER_IN |-> ##2 !ENABLE_OUT && !BUSY_OUT)
		else $error("low power left unit running");
	a_reset_out: assert property ($fell(SYS_RST_IN) |-> !ENABLE_OUT
		&& !BUSY_OUT && RDATA_OUT == 8'h00)
		else $error("outputs not clear after reset");
endmodule

bind mau_top mau_checker #(.BUSY_A_CYCLES(BUSY_A_CYCLES)) u_chk (
	.CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN), .LOW_POWER_IN(LOW_POWER_IN),
	.ADDR_IN(ADDR_IN), .WR_IN(WR_IN), .WDATA_IN(WDATA_IN),
	.RDATA_OUT(RDATA_OUT), .BUSY_OUT(BUSY_OUT), .ENABLE_OUT(ENABLE_OUT)
);

// *** sim/mau_host_model.sv ***
`timescale 1ns/1ps
module mau_host_model (
	// Clock
	input  wire       clk,
	// Unit answers
	input  wire [7:0] rdata,
	input  wire       busy,
	// Byte writes
	output reg  [3:0] addr,
	output reg        wr,
	output reg  [7:0] wdata
);
	initial begin
		addr = 4'h0;
		wr = 1'b0;
		wdata = 8'h00;
	end
	task wrb(input [3:0] a, input [7:0] d);
	begin
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	end
	endtask
	task rdb(input [3:0] a, output [7:0] d);
	begin
		@(posedge clk);
		addr <= a;
		@(posedge clk);
		#1 d = rdata;
	end
	endtask
	task wr32(input [31:0] v);
		integer i;
	begin
		for (i = 0; i < 4; i = i + 1)
			wrb(4'hA + i[3:0], v[8*i +: 8]);
	end
	endtask
	task rd32(output [31:0] v);
		integer i;
		reg [7:0] d;
	begin
		for (i = 0; i < 4; i = i + 1) begin
			rdb(4'hA + i[3:0], d);
			v[8*i +: 8] = d;
		end
	end
	endtask
	// Multiplier goes first since the multiplicand high byte starts work.
	task op(input [15:0] a, input [15:0] b);
	begin
		wrb(4'h6, a[7:0]);
		wrb(4'h7, a[15:8]);
		wrb(4'h8, b[7:0]);
		wrb(4'h9, b[15:8]);
	end
	endtask
	// Mode and addend are only changed once this returns.
	task idle;
		integer n;
	begin
		n = 0;
		repeat (4) @(posedge clk);
		while (busy !== 1'b0 && n < 64) begin
			@(posedge clk);
			n = n + 1;
		end
	end
	endtask
endmodule

// *** sim/test_multiply_accumulate_unit.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks = num_checks + 1; if ((g) !== (e)) \
	begin err_count = err_count + 1; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module test_multiply_accumulate_unit;
	reg         clk;
	reg         rst;
	reg         lp;
	wire [3:0]  addr;
	wire        wr;
	wire [7:0]  wdata;
	wire [7:0]  rdata;
	wire        busy;
	wire        en;
	reg  [66:0] rows [0:7];
	reg  [2:0]  m;
	reg  [15:0] a;
	reg  [15:0] b;
	reg  [31:0] ad;
	reg  [31:0] r;
	reg  [7:0]  st;
	integer     i;
	integer     cyc;
	integer     err_count;
	integer     num_checks;
	mau_top #(.BUSY_A_CYCLES(3)) DUT (.CLK_IN(clk), .SYS_RST_IN(rst),
		.LOW_POWER_IN(lp), .ADDR_IN(addr), .WR_IN(wr), .WDATA_IN(wdata),
		.RDATA_OUT(rdata), .BUSY_OUT(busy), .ENABLE_OUT(en));
	mau_host_model host (.clk(clk), .rdata(rdata), .busy(busy),
		.addr(addr), .wr(wr), .wdata(wdata));
	always #4 clk = ~clk;
	function [39:0] mac_exp(input [2:0] fm, input [15:0] fa,
		input [15:0] fb, input [31:0] fd);
		reg [31:0] p;
		reg [32:0] s;
	begin
		if (fm[1])
			p = $signed(fa) * $signed(fb);
		else
			p = fa * fb;
		s = fm[0] ? {1'b0, p} + {1'b0, fd} : {1'b0, p};
		mac_exp = {3'b111, s[32], s[31:0] == 32'h0000_0000, s[31],
			fm[1] & fm[0] & (p[31] == fd[31]) & (s[31] != p[31]),
			1'b0, s[31:0]};
	end
	endfunction
	task report_and_stop;
	begin
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	end
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count = err_count + 1;
			report_and_stop;
		end
	end
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		lp = 1'b0;
		cyc = 0;
		err_count = 0;
		num_checks = 0;
		rows[0] = {3'h0, 16'hFFFF, 16'hFFFF, 32'h0000_0005};
		rows[1] = {3'h2, 16'h8000, 16'h8000, 32'h0000_0000};
		rows[2] = {3'h2, 16'h8000, 16'h7FFF, 32'h0000_0000};
		rows[3] = {3'h2, 16'h0000, 16'hFFFF, 32'h0000_0007};
		rows[4] = {3'h1, 16'hFFFF, 16'hFFFF, 32'h0001_FFFF};
		rows[5] = {3'h1, 16'h0002, 16'h0003, 32'h0000_0010};
		rows[6] = {3'h3, 16'h7FFF, 16'h7FFF, 32'h7FFF_FFFF};
		rows[7] = {3'h3, 16'h8000, 16'h7FFF, 32'h8000_0000};
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		for (i = 0; i < 8; i = i + 1) begin
			{m, a, b, ad} = rows[i];
			host.wrb(4'h4, 8'h88 | {5'h00, m});
			host.wr32(ad);
			host.rd32(r);
			`CHK(r, ad)
			host.op(a, b);
			host.idle;
			host.rd32(r);
			host.rdb(4'h5, st);
			`CHK({st, r}, mac_exp(m, a, b, ad))
			$display("row %0d done", i);
		end
		host.wrb(4'h4, 8'h89);
		host.op(16'h0002, 16'h0003);
		host.wrb(4'h8, 8'h03);
		host.wrb(4'h9, 8'h00);
		host.idle;
		host.rd32(r);
		`CHK(r, 32'h0000_000C)
		host.wrb(4'h4, 8'h81);
		host.rd32(r);
		`CHK(r, 32'h0000_000C)
		$display("accumulate done");
		host.op(16'h0001, 16'h0001);
		host.wrb(4'h4, 8'h89);
		host.idle;
		host.rd32(r);
		`CHK(r, 32'h0000_000D)
		host.wrb(4'h4, 8'h89);
		host.rdb(4'h4, st);
		`CHK(st, 8'hF1)
		host.rd32(r);
		host.rdb(4'h5, st);
		`CHK({st, r}, 40'hE0_0000_0000)
		$display("clear done");
		host.wrb(4'h4, 8'h01);
		host.rdb(4'h4, st);
		`CHK(st, 8'h71)
		host.wr32(32'h1234_5678);
		host.wrb(4'h4, 8'h81);
		host.rd32(r);
		`CHK(r, 32'h0000_0000)
		host.rdb(4'hF, st);
		`CHK(st, 8'h00)
		@(posedge clk);
		lp <= 1'b1;
		@(posedge clk);
		lp <= 1'b0;
		host.rdb(4'h4, st);
		`CHK({en, st}, 9'h070)
		@(posedge clk);
		rst <= 1'b1;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		host.rdb(4'h5, st);
		`CHK(st, 8'hE0)
		$display("power and reset done");
		report_and_stop;
	end
endmodule
